// *** design/rltc_map.svh ***
// register offsets, field positions, reset values and timing counts
`ifndef RLTC_MAP_SVH
`define RLTC_MAP_SVH

`define RLTC_OFS_CAL_LOW 8'h04
`define RLTC_OFS_CAL_HIGH_MISC 8'h05
`define RLTC_OFS_TX_WAIT 8'h06
`define RLTC_OFS_NO_REPLY 8'h07
`define RLTC_OFS_RX_IGNORE 8'h08
`define RLTC_OFS_RX_FILTER 8'h09
`define RLTC_OFS_RX_GAIN_MIX 8'h0a

`define RLTC_RST_CAL_HIGH_MISC 8'h05
`define RLTC_RST_TX_WAIT 8'h00
`define RLTC_RST_NO_REPLY 8'h07
`define RLTC_RST_RX_IGNORE 8'h07
`define RLTC_RST_RX_FILTER 8'h41
`define RLTC_RST_RX_GAIN_MIX 8'h01

// register 05 fields
`define RLTC_GAIN_DIR_BIT 7
`define RLTC_MIX_LOW_BIT 6
`define RLTC_IO_LOW_BIT 5
`define RLTC_OPEN_DRAIN_BIT 4
// register 09 fields
`define RLTC_BYP_HIGH_BIT 7
`define RLTC_BYP_LOW_BIT 6
// register 0a fields
`define RLTC_GAIN_STEP_HI 7
`define RLTC_GAIN_STEP_LO 6
`define RLTC_HYST_HI 5
`define RLTC_HYST_LO 3
`define RLTC_SINGLE_MIX_BIT 2
`define RLTC_BOOST_BIT 1
`define RLTC_ATTEN_BIT 0

// time steps in ns, system clock period in ns
`define RLTC_CLK_PERIOD_NS 8
`define RLTC_CAL_UNIT_NS 100
`define RLTC_FINE_STEP_NS 6400
`define RLTC_COARSE_STEP_NS 25600
// detected reply periods needed to cancel the no-reply event
`define RLTC_REPLY_PERIODS 6

`endif

// *** design/rltc_pkg.sv ***
// types for the link timing and receive configuration block
`default_nettype none
package rltc_pkg;
    typedef enum logic [1:0] {
        RLTC_IDLE = 2'b00,
        RLTC_RUN = 2'b01
    } rltc_timer_state_t;
endpackage
`default_nettype wire

// *** design/rltc_wait_timer.sv ***
// one wait timer counting time-base ticks after a start event
`default_nettype none
module rltc_wait_timer #(
    parameter int WIDTH = 8
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic start,
    input wire logic cancel,
    input wire logic tick,
    input wire logic [WIDTH-1:0] length,
    output logic busy,
    output logic expire
);
    rltc_pkg::rltc_timer_state_t state;
    logic [WIDTH-1:0] remain;

    initial begin
        if (WIDTH < 1) begin
            $error("rltc_wait_timer: WIDTH must be at least one");
        end
    end

    // restart wins over cancel so a fresh start is never lost
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= rltc_pkg::RLTC_IDLE;
            remain <= '0;
            expire <= 1'b0;
        end else begin
            expire <= 1'b0;
            if (start) begin
                remain <= length;
                state <= (length == '0) ? rltc_pkg::RLTC_IDLE
                                         : rltc_pkg::RLTC_RUN;
            end else if (cancel) begin
                state <= rltc_pkg::RLTC_IDLE;
            end else begin
                unique case (state)
                    rltc_pkg::RLTC_IDLE: begin
                    end
                    rltc_pkg::RLTC_RUN: begin
                        if (tick) begin
                            remain <= remain - 1'b1;
                            if (remain == WIDTH'(1)) begin
                                state <= rltc_pkg::RLTC_IDLE;
                                expire <= 1'b1;
                            end
                        end
                    end
                    default: state <= rltc_pkg::RLTC_IDLE;
                endcase
            end
        end
    end

    assign busy = (state == rltc_pkg::RLTC_RUN);
endmodule
`default_nettype wire

// *** design/rltc_config.sv ***
// link timing and receive configuration registers 05 to 0a
`include "rltc_map.svh"
`default_nettype none
module rltc_config #(
    parameter int CLK_PERIOD_NS = `RLTC_CLK_PERIOD_NS,
    parameter int REPLY_PERIODS = `RLTC_REPLY_PERIODS
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic chip_enable,
    // host register port
    input wire logic [7:0] reg_addr,
    input wire logic reg_write,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    // low calibration byte held by the neighbouring register
    input wire logic [7:0] cal_low,
    // sequencing events
    input wire logic rx_end,
    input wire logic tx_end,
    input wire logic tx_request,
    input wire logic link_period_seen,
    // timing results
    output logic tx_go,
    output logic tx_hold,
    output logic rx_ignore,
    output logic no_reply_event,
    output logic [11:0] reverse_link_calibration,
    // pin and analog controls
    output logic open_drain_select,
    output logic io_low_resistance,
    output logic mixer_supply_low,
    output logic gain_increase,
    output logic [1:0] gain_step,
    output logic [2:0] hysteresis_step,
    output logic single_ended_mixer,
    output logic mixer_gain_boost,
    output logic mixer_input_attenuate,
    output logic bypass_high_link_filter,
    output logic bypass_low_link_filter,
    output logic [2:0] lowpass_select,
    output logic [2:0] highpass_select
);
    // fine step in clock cycles; coarse step is four fine steps
    localparam int FINE_CYCLES = `RLTC_FINE_STEP_NS / CLK_PERIOD_NS;
    localparam int COARSE_PER_FINE =
        `RLTC_COARSE_STEP_NS / `RLTC_FINE_STEP_NS;
    localparam int CAL_UNIT_CYCLES = `RLTC_CAL_UNIT_NS / CLK_PERIOD_NS;

    initial begin
        if (CLK_PERIOD_NS < 1 || FINE_CYCLES < 2 || FINE_CYCLES > 65535) begin
            $error("rltc_config: clock period unsuitable for tick divider");
        end
        if (REPLY_PERIODS < 1 || REPLY_PERIODS > 15) begin
            $error("rltc_config: REPLY_PERIODS must be 1 to 15");
        end
    end

    // ==========================================================
    // registers
    logic [7:0] cal_high_misc;
    logic [7:0] tx_wait;
    logic [7:0] no_reply;
    logic [7:0] rx_ignore_len;
    logic [7:0] rx_filter;
    logic [7:0] rx_gain_mix;

    // read decode used for data only; valid follows every read strobe
    function automatic logic mapped(input logic [7:0] a);
        mapped = (a >= `RLTC_OFS_CAL_HIGH_MISC) &&
                 (a <= `RLTC_OFS_RX_GAIN_MIX);
    endfunction

    // chip enable low acts as a preset, same as power-on
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cal_high_misc <= `RLTC_RST_CAL_HIGH_MISC;
            tx_wait <= `RLTC_RST_TX_WAIT;
            no_reply <= `RLTC_RST_NO_REPLY;
            rx_ignore_len <= `RLTC_RST_RX_IGNORE;
            rx_filter <= `RLTC_RST_RX_FILTER;
            rx_gain_mix <= `RLTC_RST_RX_GAIN_MIX;
        end else if (!chip_enable) begin
            cal_high_misc <= `RLTC_RST_CAL_HIGH_MISC;
            tx_wait <= `RLTC_RST_TX_WAIT;
            no_reply <= `RLTC_RST_NO_REPLY;
            rx_ignore_len <= `RLTC_RST_RX_IGNORE;
            rx_filter <= `RLTC_RST_RX_FILTER;
            rx_gain_mix <= `RLTC_RST_RX_GAIN_MIX;
        end else if (reg_write) begin
            unique case (reg_addr)
                `RLTC_OFS_CAL_HIGH_MISC: cal_high_misc <= reg_wdata;
                `RLTC_OFS_TX_WAIT: tx_wait <= reg_wdata;
                `RLTC_OFS_NO_REPLY: no_reply <= reg_wdata;
                `RLTC_OFS_RX_IGNORE: rx_ignore_len <= reg_wdata;
                `RLTC_OFS_RX_FILTER: rx_filter <= reg_wdata;
                `RLTC_OFS_RX_GAIN_MIX: rx_gain_mix <= reg_wdata;
                default: begin
                end
            endcase
        end
    end

    // read answer one cycle after the strobe; unmapped reads as zero
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata <= 8'h00;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_read;
            if (reg_read && mapped(reg_addr)) begin
                unique case (reg_addr)
                    `RLTC_OFS_CAL_HIGH_MISC: reg_rdata <= cal_high_misc;
                    `RLTC_OFS_TX_WAIT: reg_rdata <= tx_wait;
                    `RLTC_OFS_NO_REPLY: reg_rdata <= no_reply;
                    `RLTC_OFS_RX_IGNORE: reg_rdata <= rx_ignore_len;
                    `RLTC_OFS_RX_FILTER: reg_rdata <= rx_filter;
                    `RLTC_OFS_RX_GAIN_MIX: reg_rdata <= rx_gain_mix;
                    default: reg_rdata <= 8'h00;
                endcase
            end else if (reg_read) begin
                reg_rdata <= 8'h00;
            end
        end
    end

    // ==========================================================
    // configuration outputs, all registered
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            reverse_link_calibration <= 12'h000;
            gain_increase <= 1'b0;
            mixer_supply_low <= 1'b0;
            io_low_resistance <= 1'b0;
            open_drain_select <= 1'b0;
            gain_step <= 2'h0;
            hysteresis_step <= 3'h0;
            single_ended_mixer <= 1'b0;
            mixer_gain_boost <= 1'b0;
            mixer_input_attenuate <= 1'b0;
            bypass_high_link_filter <= 1'b0;
            bypass_low_link_filter <= 1'b0;
            lowpass_select <= 3'h0;
            highpass_select <= 3'h0;
        end else begin
            // twelve bits in 0.1 us units, high nibble here
            reverse_link_calibration <= {cal_high_misc[3:0], cal_low};
            gain_increase <= cal_high_misc[`RLTC_GAIN_DIR_BIT];
            mixer_supply_low <= cal_high_misc[`RLTC_MIX_LOW_BIT];
            io_low_resistance <= cal_high_misc[`RLTC_IO_LOW_BIT];
            open_drain_select <= cal_high_misc[`RLTC_OPEN_DRAIN_BIT];
            gain_step <= rx_gain_mix[`RLTC_GAIN_STEP_HI:`RLTC_GAIN_STEP_LO];
            hysteresis_step <= rx_gain_mix[`RLTC_HYST_HI:`RLTC_HYST_LO];
            single_ended_mixer <= rx_gain_mix[`RLTC_SINGLE_MIX_BIT];
            mixer_gain_boost <= rx_gain_mix[`RLTC_BOOST_BIT];
            mixer_input_attenuate <= rx_gain_mix[`RLTC_ATTEN_BIT];
            bypass_high_link_filter <= rx_filter[`RLTC_BYP_HIGH_BIT];
            bypass_low_link_filter <= rx_filter[`RLTC_BYP_LOW_BIT];
            lowpass_select <= rx_filter[5:3];
            highpass_select <= rx_filter[2:0];
        end
    end

    // ==========================================================
    // shared time base: fine tick every 6.4 us, coarse every 25.6 us
    logic [15:0] fine_div;
    logic [1:0] coarse_div;
    logic fine_tick;
    logic coarse_tick;

    // ticks are free running, so first step may be short by one tick
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            fine_div <= 16'h0000;
            coarse_div <= 2'h0;
            fine_tick <= 1'b0;
            coarse_tick <= 1'b0;
        end else begin
            fine_tick <= 1'b0;
            coarse_tick <= 1'b0;
            if (fine_div == 16'(FINE_CYCLES - 1)) begin
                fine_div <= 16'h0000;
                fine_tick <= 1'b1;
                if (coarse_div == 2'(COARSE_PER_FINE - 1)) begin
                    coarse_div <= 2'h0;
                    coarse_tick <= 1'b1;
                end else begin
                    coarse_div <= coarse_div + 2'h1;
                end
            end else begin
                fine_div <= fine_div + 16'h0001;
            end
        end
    end

    // ==========================================================
    // reply detection: count link periods seen after transmit
    logic [3:0] reply_count;
    logic reply_found;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            reply_count <= 4'h0;
            reply_found <= 1'b0;
        end else if (tx_end) begin
            reply_count <= 4'h0;
            reply_found <= 1'b0;
        end else if (link_period_seen && !reply_found) begin
            if (reply_count == 4'(REPLY_PERIODS - 1)) begin
                reply_found <= 1'b1;
            end
            reply_count <= reply_count + 4'h1;
        end
    end

    // ==========================================================
    // the three wait timers
    logic tx_busy, tx_done;
    logic nr_busy, nr_done;
    logic ig_busy;

    rltc_wait_timer #(.WIDTH(8)) u_tx_timer (
        .clk(clk),
        .rst_b(rst_b),
        .start(rx_end),
        .cancel(!chip_enable),
        .tick(fine_tick),
        .length(tx_wait),
        .busy(tx_busy),
        .expire(tx_done)
    );

    rltc_wait_timer #(.WIDTH(8)) u_no_reply_timer (
        .clk(clk),
        .rst_b(rst_b),
        .start(tx_end),
        .cancel(reply_found || !chip_enable),
        .tick(coarse_tick),
        .length(no_reply),
        .busy(nr_busy),
        .expire(nr_done)
    );

    rltc_wait_timer #(.WIDTH(8)) u_ignore_timer (
        .clk(clk),
        .rst_b(rst_b),
        .start(tx_end),
        .cancel(!chip_enable),
        .tick(fine_tick),
        .length(rx_ignore_len),
        .busy(ig_busy),
        .expire()
    );

    // ==========================================================
    // sequencing outputs; a pending transmit request waits for the timer
    logic tx_pending;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            tx_pending <= 1'b0;
            tx_go <= 1'b0;
            tx_hold <= 1'b0;
            rx_ignore <= 1'b0;
            no_reply_event <= 1'b0;
        end else begin
            tx_go <= 1'b0;
            no_reply_event <= nr_done && !reply_found;
            rx_ignore <= ig_busy || (tx_end && rx_ignore_len != 8'h00);
            tx_hold <= tx_busy;
            if (tx_request && !tx_busy && !rx_end) begin
                tx_go <= 1'b1;
                tx_pending <= 1'b0;
            end else if (tx_request) begin
                tx_pending <= 1'b1;
            end else if (tx_pending && (tx_done || !tx_busy)) begin
                tx_go <= 1'b1;
                tx_pending <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// *** verif/rltc_config_monitor.sv ***
// port checker for the link timing and receive configuration block
`default_nettype none
module rltc_config_monitor (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic chip_enable,
    input wire logic [7:0] reg_addr,
    input wire logic reg_write,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_read,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rvalid,
    input wire logic [7:0] cal_low,
    input wire logic rx_end,
    input wire logic tx_request,
    input wire logic tx_hold,
    input wire logic tx_go,
    input wire logic no_reply_event,
    input wire logic [11:0] reverse_link_calibration,
    input wire logic [1:0] gain_step,
    input wire logic [2:0] hysteresis_step,
    input wire logic single_ended_mixer,
    input wire logic mixer_gain_boost,
    input wire logic mixer_input_attenuate,
    input wire logic bypass_high_link_filter,
    input wire logic bypass_low_link_filter,
    input wire logic [2:0] lowpass_select,
    input wire logic [2:0] highpass_select
);
    default clocking mon_cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    // ==========================================================
    // helpers
    // edges since reset, so $past in the live-gated checks never looks back into reset
    logic [1:0] up_cnt;
    logic live;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            up_cnt <= 2'h0;
        end else if (up_cnt != 2'h3) begin
            up_cnt <= up_cnt + 2'h1;
        end
    end
    assign live = (up_cnt == 2'h3);
    sequence wr_at(logic [7:0] a);
        reg_write && chip_enable && reg_addr == a;
    endsequence
    sequence rd_gap;
        reg_read && (reg_addr < 8'h05 || reg_addr > 8'h0a);
    endsequence
    // ==========================================================
    // assertions
    rvalid_pulse_a: assert property (
        live |-> reg_rvalid == $past(reg_read))
        else $error("read valid out of step with read strobe");
    unmapped_zero_a: assert property (
        rd_gap |=> reg_rdata == 8'h00)
        else $error("unmapped read gave nonzero data");
    rdata_hold_a: assert property (
        !reg_read |=> $stable(reg_rdata))
        else $error("read data moved without a read");
    cal_low_a: assert property (
        live |-> reverse_link_calibration[7:0] == $past(cal_low))
        else $error("calibration low byte not passed on");
    filter_write_a: assert property (
        wr_at(8'h09) |=> ##1 {bypass_high_link_filter,
        bypass_low_link_filter, lowpass_select, highpass_select}
        == $past(reg_wdata, 2))
        else $error("filter outputs differ from written value");
    mix_write_a: assert property (
        wr_at(8'h0a) |=> ##1 {gain_step, hysteresis_step,
        single_ended_mixer, mixer_gain_boost, mixer_input_attenuate}
        == $past(reg_wdata, 2))
        else $error("gain and mixer outputs differ from written value");
    tx_go_a: assert property (
        tx_request && chip_enable && !tx_hold && !rx_end
        && !$past(rx_end) && !$past(rx_end, 2) |=> tx_go)
        else $error("transmit not released with no wait pending");
    noreply_pulse_a: assert property (
        no_reply_event |=> !no_reply_event)
        else $error("no reply event longer than one cycle");
endmodule
bind rltc_config rltc_config_monitor u_rltc_config_monitor (
    .clk(clk), .rst_b(rst_b), .chip_enable(chip_enable),
    .reg_addr(reg_addr), .reg_write(reg_write), .reg_wdata(reg_wdata),
    .reg_read(reg_read), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .cal_low(cal_low), .rx_end(rx_end), .tx_request(tx_request),
    .tx_hold(tx_hold), .tx_go(tx_go), .no_reply_event(no_reply_event),
    .reverse_link_calibration(reverse_link_calibration),
    .gain_step(gain_step), .hysteresis_step(hysteresis_step),
    .single_ended_mixer(single_ended_mixer),
    .mixer_gain_boost(mixer_gain_boost),
    .mixer_input_attenuate(mixer_input_attenuate),
    .bypass_high_link_filter(bypass_high_link_filter),
    .bypass_low_link_filter(bypass_low_link_filter),
    .lowpass_select(lowpass_select), .highpass_select(highpass_select)
);
`default_nettype wire

// *** verif/rltc_tag_model.sv ***
// behavioural tag on the air side: answers a transmit with link periods
`default_nettype none
module rltc_tag_model #(
    parameter int FAST_DELAY = 100,
    parameter int SLOW_DELAY = 1000,
    parameter int PERIOD = 25,
    parameter int PULSES = 8
) (
    input wire logic clk,
    input wire logic tx_end,
    input wire logic reply_on,
    input wire logic reply_slow,
    output logic link_period_seen
);
    // ==========================================================
    // reply: a silent tag leaves the detector line idle low
    initial begin
        link_period_seen = 1'b0;
        forever begin
            @(posedge clk);
            if (tx_end && reply_on) begin
                repeat (reply_slow ? SLOW_DELAY : FAST_DELAY) @(posedge clk);
                repeat (PULSES) begin
                    #1 link_period_seen = 1'b1;
                    @(posedge clk);
                    #1 link_period_seen = 1'b0;
                    repeat (PERIOD - 1) @(posedge clk);
                end
            end
        end
    end
endmodule
`default_nettype wire

// *** verif/rltc_config_bench.sv ***
// self-checking bench for the link timing and receive configuration block
`default_nettype none
module rltc_config_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst_b, chip_enable, reg_write, reg_read, reg_rvalid;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, cal_low;
    logic rx_end, tx_end, tx_request, link_period_seen, tx_go, tx_hold;
    logic rx_ignore, no_reply_event, open_drain_select, io_low_resistance;
    logic mixer_supply_low, gain_increase, single_ended_mixer;
    logic mixer_gain_boost, mixer_input_attenuate;
    logic bypass_high_link_filter, bypass_low_link_filter;
    logic [1:0] gain_step;
    logic [2:0] hysteresis_step, lowpass_select, highpass_select;
    logic [11:0] reverse_link_calibration;
    logic reply_on, reply_slow;
    logic [7:0] v5, v9, va;
    logic [7:0] rst_val [6] = '{8'h05, 8'h00, 8'h07, 8'h07, 8'h41, 8'h01};
    logic [7:0] pat [2] = '{8'ha5, 8'h5a};
    int fail_count = 0;
    int samples_checked = 0;
    int cycles = 0;
    int n;
    // outputs regrouped in register bit order
    assign v5 = {gain_increase, mixer_supply_low, io_low_resistance,
        open_drain_select, reverse_link_calibration[11:8]};
    assign v9 = {bypass_high_link_filter, bypass_low_link_filter,
        lowpass_select, highpass_select};
    assign va = {gain_step, hysteresis_step, single_ended_mixer,
        mixer_gain_boost, mixer_input_attenuate};
    rltc_config u_rltc_config (.clk(clk), .rst_b(rst_b),
        .chip_enable(chip_enable), .reg_addr(reg_addr),
        .reg_write(reg_write), .reg_wdata(reg_wdata), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .cal_low(cal_low),
        .rx_end(rx_end), .tx_end(tx_end), .tx_request(tx_request),
        .link_period_seen(link_period_seen), .tx_go(tx_go),
        .tx_hold(tx_hold), .rx_ignore(rx_ignore),
        .no_reply_event(no_reply_event),
        .reverse_link_calibration(reverse_link_calibration),
        .open_drain_select(open_drain_select),
        .io_low_resistance(io_low_resistance),
        .mixer_supply_low(mixer_supply_low), .gain_increase(gain_increase),
        .gain_step(gain_step), .hysteresis_step(hysteresis_step),
        .single_ended_mixer(single_ended_mixer),
        .mixer_gain_boost(mixer_gain_boost),
        .mixer_input_attenuate(mixer_input_attenuate),
        .bypass_high_link_filter(bypass_high_link_filter),
        .bypass_low_link_filter(bypass_low_link_filter),
        .lowpass_select(lowpass_select), .highpass_select(highpass_select));
    rltc_tag_model u_rltc_tag_model (.clk(clk), .tx_end(tx_end),
        .reply_on(reply_on), .reply_slow(reply_slow),
        .link_period_seen(link_period_seen));
    // ==========================================================
    // clock and hang guard
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 90000) begin
            fail_count++;
            stop_test();
        end
    end
    // ==========================================================
    // tasks: every task starts and ends 1 ns after a rising edge
    task automatic stop_test();
        $display("checked %0d bad %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic check_val(input logic [11:0] got, input logic [11:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic check_time(input int got, input int lo, input int hi);
        samples_checked++;
        if (got < lo || got > hi) begin
            fail_count++;
            $display("BAD t=%0t got %h exp %h..%h", $time, got, lo, hi);
        end
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_write = 1'b1;
        tick(1);
        reg_write = 1'b0;
        // one idle edge so back-to-back calls never retoggle the strobe
        tick(1);
    endtask
    task automatic read_reg(input logic [7:0] a, input logic [7:0] exp);
        reg_addr = a;
        reg_read = 1'b1;
        tick(1);
        reg_read = 1'b0;
        check_val({3'h0, reg_rvalid, reg_rdata}, {4'h1, exp});
        tick(1);
    endtask
    // one-cycle event: 0 receive end, 1 transmit end, 2 transmit request
    task automatic pulse(input int which);
        rx_end = (which == 0);
        tx_end = (which == 1);
        tx_request = (which == 2);
        tick(1);
        {rx_end, tx_end, tx_request} = 3'h0;
    endtask
    // cycles until: 0 transmit go, 1 no reply event, 2 ignore window off
    task automatic measure(input int which, output int k);
        k = 0;
        while (k < 12000 && !((which == 0 && tx_go === 1'b1) ||
                (which == 1 && no_reply_event === 1'b1) ||
                (which == 2 && rx_ignore === 1'b0))) begin
            tick(1);
            k++;
        end
    endtask
    task automatic check_presets();
        for (int i = 0; i < 6; i++) begin
            read_reg(8'h05 + i[7:0], rst_val[i]);
        end
        check_val({4'h0, v5}, {4'h0, rst_val[0]});
        check_val({4'h0, v9}, {4'h0, rst_val[4]});
        check_val({4'h0, va}, {4'h0, rst_val[5]});
    endtask
    // ==========================================================
    // main sequence
    initial begin
        {rst_b, reg_write, reg_read, rx_end, tx_end, tx_request} = 6'h00;
        {reply_on, reply_slow, reg_addr, reg_wdata} = 18'h00000;
        chip_enable = 1'b1;
        cal_low = 8'h3c;
        tick(2);
        rst_b = 1'b1;
        check_presets();
        check_val(reverse_link_calibration, 12'h53c);
        $display("test presets done");
        // each bit both ways, registers written back to back
        for (int p = 0; p < 2; p++) begin
            cal_low = pat[p];
            for (int i = 0; i < 6; i++) begin
                write_reg(8'h05 + i[7:0], pat[p] ^ i[7:0]);
            end
            tick(1);
            check_val({4'h0, v5}, {4'h0, pat[p]});
            check_val({4'h0, v9}, {4'h0, pat[p] ^ 8'h04});
            check_val({4'h0, va}, {4'h0, pat[p] ^ 8'h05});
            check_val(reverse_link_calibration, {pat[p][3:0], pat[p]});
            for (int i = 0; i < 6; i++) begin
                read_reg(8'h05 + i[7:0], pat[p] ^ i[7:0]);
            end
        end
        $display("test fields done");
        read_reg(8'h04, 8'h00);
        write_reg(8'h0b, 8'hff);
        read_reg(8'h0b, 8'h00);
        read_reg(8'h0a, 8'h5f);
        // enable low presets and blocks a write made meanwhile
        chip_enable = 1'b0;
        write_reg(8'h0a, 8'hff);
        chip_enable = 1'b1;
        check_presets();
        $display("test enable done");
        pulse(0);
        pulse(2);
        check_val({11'h0, tx_go}, 12'h001);
        write_reg(8'h06, 8'h03);
        pulse(0);
        pulse(2);
        check_val({10'h0, tx_hold, tx_go}, 12'h002);
        measure(0, n);
        check_time(n, 1590, 3200);
        $display("test transmit wait done");
        // no reply timer off so later transmit ends stay quiet
        write_reg(8'h07, 8'h00);
        write_reg(8'h08, 8'h00);
        pulse(1);
        check_val({11'h0, rx_ignore}, 12'h000);
        write_reg(8'h08, 8'h04);
        pulse(1);
        tick(2000);
        check_val({11'h0, rx_ignore}, 12'h001);
        pulse(1);
        measure(2, n);
        check_time(n, 2390, 4000);
        $display("test ignore window done");
        write_reg(8'h08, 8'h00);
        write_reg(8'h07, 8'h02);
        pulse(1);
        measure(1, n);
        check_time(n, 3190, 9602);
        for (int s = 0; s < 2; s++) begin
            reply_on = 1'b1;
            reply_slow = s[0];
            pulse(1);
            measure(1, n);
            check_time(n, 12000, 12000);
        end
        $display("test no reply done");
        stop_test();
    end
endmodule
`default_nettype wire
